// ### mmusr_regs.sv
// Status 0/1/2 registers and internal data bus read multiplexer.
// Assumes the processor supplies one-cycle strobes in the clk_i domain.
`timescale 1ns/1ps
`include "mmusr_defs.svh"

// Functional notes
// - Clear instruction-complete at new instruction if no paging error before.
// - Set instruction-complete when interrupt-entry microstate is decoded.
// - Mode field codes kernel 00, supervisor 01, user 11.
// - Mode 10 selects no space; every access aborts while relocation is active.
// - Load mode, I/D and page at pause end under strobe conditions.
// - After a paging error the faulting mode field is kept.
// - I/D bit is 1 for data space, 0 for instruction space.
// - Page number from virtual address 15:13 into bits 3:1.
// - Relocation enable bit is set only by a software write.
// - Console physical access suppresses relocation.
// - Status 1 is 16-bit and read only.
// - First modification to low byte, second to high byte.
// - Register number in low three bits; register 17 logs as R6.
// - Amount in bits 6:3 or 14:11; constants 1, 2, 4, 8.
// - Decrement stores two's complement; increment stores plain constant.
// - Byte MSB is sign: 1 decrement, 0 increment.
// - Instruction register load clears status 1 and seen flag.
// - Interrupt entry with no error clears status 1 and seen flag.
// - Status 2 loads the virtual address at each instruction fetch.
// - Status 2 loads the trap vector at interrupt or trap start.
// - Status 2 ignores software writes.
// - Read mux selects by address 2:1 or page register.
// - Drive data bus only on read strobe, hit, no yield.
// - Status registers decode at 777572, 777574, 777576.
module mmusr_regs
   import mmusr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Processor address and cycle timing
   input wire logic [15:0] virt_addr_i,
   input wire logic bust_t5_i,
   input wire logic pause_end_i,
   input wire logic bus_end_abandon_i,
   input wire logic page_register_hit_i,
   input wire logic paging_error_i,
   // Current space mode one-hot decode and space
   input wire logic kernel_space_i,
   input wire logic super_space_i,
   input wire logic user_space_i,
   input wire logic data_space_i,
   input wire logic console_physical_access_i,
   // Register write from the processor
   input wire logic write_strobe_i,
   input wire logic [15:0] write_data_i,
   // Microstate decodes
   input wire logic interrupt_entry_microstate_i,
   input wire logic instruction_register_load_i,
   input wire logic instruction_load_microfield_i,
   input wire logic [15:0] trap_vector_i,
   // Register modification events
   input wire logic modify_event_i,
   input wire logic [3:0] general_register_number_i,
   input wire logic [3:0] modify_constant_select_i,
   input wire logic decrement_flag_i,
   // Page register and read path
   input wire logic [15:0] page_register_pair_i,
   input wire logic processor_read_strobe_i,
   input wire logic bus_yield_request_i,
   // Outputs
   output logic relocation_active_o,
   output logic abort_no_space_o,
   output logic status_register_hit_o,
   output logic [15:0] int_bus_data_o,
   output logic int_bus_drive_o
);
   mmusr_word_t fsc_q;
   mmusr_word_t rmr_q;
   mmusr_word_t iar_q;
   logic one_modification_seen_q;
   logic hit_q;
   logic error_seen_q;
   logic hit_d;
   logic strobe_ok;
   logic new_instr;
   logic wr_fsc;
   mmusr_mode_t mode_d;
   logic [2:0] gra3;
   logic [3:0] amount;
   logic [7:0] rec_byte;
   mmusr_word_t mux_word;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      hit_d = (virt_addr_i == `MMUSR_ADDR_FSC) ||
              (virt_addr_i == `MMUSR_ADDR_RMR) ||
              (virt_addr_i == `MMUSR_ADDR_IAR);
   end

   // Hit latched at bust T5 so it stays stable over the pause cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hit_q <= 1'b0;
      end else if (bust_t5_i) begin
         hit_q <= hit_d;
      end
   end
   assign status_register_hit_o = hit_q;
   assign wr_fsc = write_strobe_i && hit_q && (virt_addr_i[2:1] == `MMUSR_SEL_FSC);

   // ----------------------------------------
   // Status 0
   // ----------------------------------------
   assign relocation_active_o = fsc_q[`MMUSR_BIT_RELOCATION_ACTIVE] && !console_physical_access_i;
   assign abort_no_space_o = relocation_active_o &&
                             (fsc_q[6:5] == `MMUSR_MODE_NONE);
   assign strobe_ok = relocation_active_o && !bus_end_abandon_i && !hit_q &&
                      !page_register_hit_i && !error_seen_q;
   assign new_instr = instruction_load_microfield_i;

   always_comb begin
      if (kernel_space_i) begin
         mode_d = `MMUSR_MODE_KERNEL;
      end else if (super_space_i) begin
         mode_d = `MMUSR_MODE_SUPER;
      end else if (user_space_i) begin
         mode_d = `MMUSR_MODE_USER;
      end else begin
         mode_d = `MMUSR_MODE_NONE;
      end
   end

   // Error flag is sticky until a new instruction; a new error wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         error_seen_q <= 1'b0;
      end else if (paging_error_i) begin
         error_seen_q <= 1'b1;
      end else if (new_instr) begin
         error_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fsc_q <= `MMUSR_RESET_WORD;
      end else begin
         if (wr_fsc) begin
            fsc_q[`MMUSR_BIT_RELOCATION_ACTIVE] <= write_data_i[0];
         end
         if (pause_end_i && strobe_ok) begin
            fsc_q[6:5] <= mode_d;
            fsc_q[`MMUSR_BIT_DSPACE] <= data_space_i;
            fsc_q[3:1] <= virt_addr_i[15:13];
         end
         if (interrupt_entry_microstate_i) begin
            fsc_q[`MMUSR_BIT_COMP] <= 1'b1;
         end else if (new_instr && !error_seen_q) begin
            fsc_q[`MMUSR_BIT_COMP] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Status 1
   // ----------------------------------------
   // Register 17 drops its low bit so it reads as R6
   assign gra3 = (general_register_number_i == `MMUSR_USP_GRA) ? 3'h6 :
                 general_register_number_i[2:0];
   assign amount = decrement_flag_i ? (~modify_constant_select_i + 4'h1) :
                   modify_constant_select_i;
   assign rec_byte = {decrement_flag_i, amount, gra3};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rmr_q <= `MMUSR_RESET_WORD;
         one_modification_seen_q <= 1'b0;
      end else if (instruction_register_load_i ||
                   (interrupt_entry_microstate_i && !error_seen_q)) begin
         // A modification in the clearing cycle starts the new record
         rmr_q <= modify_event_i ? {8'h00, rec_byte} : `MMUSR_RESET_WORD;
         one_modification_seen_q <= modify_event_i;
      end else if (modify_event_i) begin
         if (!one_modification_seen_q) begin
            rmr_q[7:0] <= rec_byte;
         end else begin
            rmr_q[15:8] <= rec_byte;
         end
         one_modification_seen_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Status 2
   // ----------------------------------------
   // No write path exists: status 1 and 2 are read only
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         iar_q <= `MMUSR_RESET_WORD;
      end else if (interrupt_entry_microstate_i) begin
         iar_q <= trap_vector_i;
      end else if (instruction_load_microfield_i) begin
         iar_q <= virt_addr_i;
      end
   end

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   always_comb begin
      if (page_register_hit_i) begin
         mux_word = page_register_pair_i;
      end else begin
         case (virt_addr_i[2:1])
            `MMUSR_SEL_FSC: mux_word = fsc_q;
            `MMUSR_SEL_RMR: mux_word = rmr_q;
            `MMUSR_SEL_IAR: mux_word = iar_q;
            default: mux_word = `MMUSR_RESET_WORD;
         endcase
      end
   end

   assign int_bus_drive_o = processor_read_strobe_i && (hit_q || page_register_hit_i) &&
                            !bus_yield_request_i;
   assign int_bus_data_o = int_bus_drive_o ? mux_word : `MMUSR_RESET_WORD;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_relocation_active_write;
      @(posedge clk_i) disable iff (srst_i)
      wr_fsc |=> (fsc_q[0] == $past(write_data_i[0]));
   endproperty
   a_relocation_active_write: assert property (p_relocation_active_write) else $error("relocation_active bit not written");

   property p_console;
      @(posedge clk_i) disable iff (srst_i)
      console_physical_access_i |-> !relocation_active_o;
   endproperty
   a_console: assert property (p_console) else $error("console access relocated");

   property p_comp_set;
      @(posedge clk_i) disable iff (srst_i)
      interrupt_entry_microstate_i |=> fsc_q[7];
   endproperty
   a_comp_set: assert property (p_comp_set) else $error("complete bit not set");

   property p_comp_clr;
      @(posedge clk_i) disable iff (srst_i)
      (new_instr && !error_seen_q && !interrupt_entry_microstate_i) |=> !fsc_q[7];
   endproperty
   a_comp_clr: assert property (p_comp_clr) else $error("complete bit not cleared");

   property p_hold_mode;
      @(posedge clk_i) disable iff (srst_i)
      error_seen_q |=> $stable(fsc_q[6:1]);
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("mode changed after error");

   property p_page;
      @(posedge clk_i) disable iff (srst_i)
      (pause_end_i && strobe_ok) |=> (fsc_q[3:1] == $past(virt_addr_i[15:13]));
   endproperty
   a_page: assert property (p_page) else $error("page number not captured");

   property p_rmr_clear;
      @(posedge clk_i) disable iff (srst_i)
      (instruction_register_load_i && !modify_event_i) |=>
         (rmr_q == 16'h0000) && !one_modification_seen_q;
   endproperty
   a_rmr_clear: assert property (p_rmr_clear) else $error("status 1 not cleared");

   property p_second_mod;
      @(posedge clk_i) disable iff (srst_i)
      (modify_event_i && one_modification_seen_q && !instruction_register_load_i &&
       !interrupt_entry_microstate_i) |=> (rmr_q[15:8] == $past(rec_byte)) && $stable(rmr_q[7:0]);
   endproperty
   a_second_mod: assert property (p_second_mod) else $error("high byte record wrong");

   property p_iar_fetch;
      @(posedge clk_i) disable iff (srst_i)
      (instruction_load_microfield_i && !interrupt_entry_microstate_i) |=>
         (iar_q == $past(virt_addr_i));
   endproperty
   a_iar_fetch: assert property (p_iar_fetch) else $error("status 2 missed fetch");

   property p_drive;
      @(posedge clk_i) disable iff (srst_i)
      bus_yield_request_i |-> !int_bus_drive_o && (int_bus_data_o == 16'h0000);
   endproperty
   a_drive: assert property (p_drive) else $error("bus driven during yield");

   property p_mode_super;
      @(posedge clk_i) disable iff (srst_i)
      (pause_end_i && strobe_ok && super_space_i && !kernel_space_i) |=>
         (fsc_q[6:5] == `MMUSR_MODE_SUPER);
   endproperty
   a_mode_super: assert property (p_mode_super) else $error("super mode code wrong");

   property p_no_space;
      @(posedge clk_i) disable iff (srst_i)
      (pause_end_i && strobe_ok && !kernel_space_i && !super_space_i && !user_space_i) |=>
         (fsc_q[6:5] == `MMUSR_MODE_NONE);
   endproperty
   a_no_space: assert property (p_no_space) else $error("no-space code wrong");

   property p_blocked;
      @(posedge clk_i) disable iff (srst_i)
      (pause_end_i && (bus_end_abandon_i || hit_q || page_register_hit_i)) |=>
         $stable(fsc_q[6:1]);
   endproperty
   a_blocked: assert property (p_blocked) else $error("capture not blocked");

   property p_dspace;
      @(posedge clk_i) disable iff (srst_i)
      (pause_end_i && strobe_ok) |=> (fsc_q[4] == $past(data_space_i));
   endproperty
   a_dspace: assert property (p_dspace) else $error("space bit wrong");

   property p_relocation_active_only;
      @(posedge clk_i) disable iff (srst_i)
      !wr_fsc |=> $stable(fsc_q[0]);
   endproperty
   a_relocation_active_only: assert property (p_relocation_active_only) else $error("enable bit moved");

   property p_rmr_ro;
      @(posedge clk_i) disable iff (srst_i)
      (write_strobe_i && !modify_event_i && !instruction_register_load_i &&
       !interrupt_entry_microstate_i) |=> $stable(rmr_q);
   endproperty
   a_rmr_ro: assert property (p_rmr_ro) else $error("status 1 written");

   property p_first_mod;
      @(posedge clk_i) disable iff (srst_i)
      (modify_event_i && !one_modification_seen_q && !instruction_register_load_i &&
       !interrupt_entry_microstate_i) |=>
         one_modification_seen_q && (rmr_q[7] == $past(decrement_flag_i)) &&
         $stable(rmr_q[15:8]);
   endproperty
   a_first_mod: assert property (p_first_mod) else $error("low byte wrong");

   property p_usp;
      @(posedge clk_i) disable iff (srst_i)
      (modify_event_i && one_modification_seen_q && !instruction_register_load_i &&
       !interrupt_entry_microstate_i && (general_register_number_i == `MMUSR_USP_GRA)) |=>
         (rmr_q[10:8] == 3'h6);
   endproperty
   a_usp: assert property (p_usp) else $error("register 17 not logged as 6");

   property p_amount_dec;
      @(posedge clk_i) disable iff (srst_i)
      (modify_event_i && one_modification_seen_q && decrement_flag_i &&
       !instruction_register_load_i && !interrupt_entry_microstate_i) |=>
         (4'(rmr_q[14:11] + $past(modify_constant_select_i)) == 4'h0) && rmr_q[15];
   endproperty
   a_amount_dec: assert property (p_amount_dec) else $error("dec amount wrong");

   property p_rmr_irq;
      @(posedge clk_i) disable iff (srst_i)
      (interrupt_entry_microstate_i && !error_seen_q && !modify_event_i) |=>
         (rmr_q == `MMUSR_RESET_WORD) && !one_modification_seen_q;
   endproperty
   a_rmr_irq: assert property (p_rmr_irq) else $error("status 1 kept at interrupt");

   property p_iar_trap;
      @(posedge clk_i) disable iff (srst_i)
      interrupt_entry_microstate_i |=> (iar_q == $past(trap_vector_i));
   endproperty
   a_iar_trap: assert property (p_iar_trap) else $error("trap vector not held");

   property p_mux_rmr;
      @(posedge clk_i) disable iff (srst_i)
      (int_bus_drive_o && !page_register_hit_i && (virt_addr_i[2:1] == `MMUSR_SEL_RMR)) |->
         (int_bus_data_o == rmr_q);
   endproperty
   a_mux_rmr: assert property (p_mux_rmr) else $error("status 1 not selected");

   property p_mux_page;
      @(posedge clk_i) disable iff (srst_i)
      (int_bus_drive_o && page_register_hit_i) |-> (int_bus_data_o == page_register_pair_i);
   endproperty
   a_mux_page: assert property (p_mux_page) else $error("page register not selected");

   property p_hit_set;
      @(posedge clk_i) disable iff (srst_i)
      (bust_t5_i && (virt_addr_i == `MMUSR_ADDR_IAR)) |=> status_register_hit_o;
   endproperty
   a_hit_set: assert property (p_hit_set) else $error("status 2 address missed");

   c_second: cover property (@(posedge clk_i) disable iff (srst_i)
      modify_event_i && one_modification_seen_q);
   c_read: cover property (@(posedge clk_i) disable iff (srst_i) int_bus_drive_o && hit_q);
   c_abort: cover property (@(posedge clk_i) disable iff (srst_i) abort_no_space_o);
endmodule

// ### mmusr_defs.svh
// Constants for the memory management status and recovery register bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MMUSR_DEFS_SVH
`define MMUSR_DEFS_SVH
`define MMUSR_ADDR_FSC 16'hff7a
`define MMUSR_ADDR_RMR 16'hff7c
`define MMUSR_ADDR_IAR 16'hff7e
`define MMUSR_SEL_FSC 2'h1
`define MMUSR_SEL_RMR 2'h2
`define MMUSR_SEL_IAR 2'h3
`define MMUSR_MODE_KERNEL 2'h0
`define MMUSR_MODE_SUPER 2'h1
`define MMUSR_MODE_NONE 2'h2
`define MMUSR_MODE_USER 2'h3
`define MMUSR_BIT_COMP 7
`define MMUSR_BIT_DSPACE 4
`define MMUSR_BIT_RELOCATION_ACTIVE 0
`define MMUSR_ACF_ABORT 3'h7
`define MMUSR_USP_GRA 4'hf
`define MMUSR_RESET_WORD 16'h0000
`endif

// ### mmusr_pkg.sv
// Types shared by the status and recovery register bank.
// Assumes the defs header sits in the same folder.
`include "mmusr_defs.svh"
package mmusr_pkg;
   typedef logic [15:0] mmusr_word_t;
   typedef logic [1:0] mmusr_mode_t;
endpackage

// ### mmusr_bus_model.sv
// Model of the processor internal data bus shared with a second talker.
// Assumes the yield request marks the cycles in which the other unit owns the bus.
`timescale 1ns/1ps
module mmusr_bus_model (
   // Clock
   input wire logic clk_i,
   // Talkers
   input wire logic dut_drive_i,
   input wire logic [15:0] dut_data_i,
   input wire logic yield_i,
   input wire logic [15:0] other_data_i,
   // Resolved level
   output logic [15:0] bus_o
);
   logic [15:0] last_q;
   // Other unit talks only under yield; a released bus shows the inverse
   // of its last value so a stale read can never pass for a match
   assign bus_o = dut_drive_i ? dut_data_i : (yield_i ? other_data_i : ~last_q);
   always_ff @(posedge clk_i) begin
      if (dut_drive_i | yield_i) begin
         last_q <= bus_o;
      end
   end
endmodule

// ### tb_mmusr.sv
// Self-checking bench for the status and recovery register bank.
// Assumes each access is a bust address phase followed by a strobe cycle.
`timescale 1ns/1ps
module tb;
   import mmusr_pkg::*;
   localparam logic [7:0] md_c = 8'hb4;
   logic clk_i = 0;
   logic srst_i = 1;
   logic [15:0] va = 16'h0, wd = 16'h0, tv = 16'h0, pp = 16'h0;
   logic bust = 0, bus_end_abandon = 0, ph = 0, cons = 0, ws = 0, ds = 0, dec = 0, rs = 0, yl = 0;
   logic [2:0] sp = 3'h1;
   logic [3:0] general_register_number = 4'h0, kc = 4'h1;
   logic [5:0] evt = 6'h0;
   logic relocation_active, abort, hit, drv;
   logic [15:0] bdat, bus, s0, rdat;
   int error_cnt = 0, samples_checked = 0;
   always #2.5 clk_i = ~clk_i;
   mmusr_regs dut (.clk_i(clk_i), .srst_i(srst_i), .virt_addr_i(va), .bust_t5_i(bust),
      .pause_end_i(evt[0]), .bus_end_abandon_i(bus_end_abandon), .page_register_hit_i(ph),
      .paging_error_i(evt[1]), .kernel_space_i(sp[0]), .super_space_i(sp[1]),
      .user_space_i(sp[2]), .data_space_i(ds), .console_physical_access_i(cons),
      .write_strobe_i(ws), .write_data_i(wd), .interrupt_entry_microstate_i(evt[2]),
      .instruction_register_load_i(evt[3]), .instruction_load_microfield_i(evt[4]),
      .trap_vector_i(tv), .modify_event_i(evt[5]), .general_register_number_i(general_register_number),
      .modify_constant_select_i(kc), .decrement_flag_i(dec), .page_register_pair_i(pp),
      .processor_read_strobe_i(rs), .bus_yield_request_i(yl), .relocation_active_o(relocation_active),
      .abort_no_space_o(abort), .status_register_hit_o(hit), .int_bus_data_o(bdat),
      .int_bus_drive_o(drv));
   mmusr_bus_model bm (.clk_i(clk_i), .dut_drive_i(drv), .dut_data_i(bdat), .yield_i(yl),
      .other_data_i(16'h0ff0), .bus_o(bus));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bst(input logic [15:0] a);
      @(posedge clk_i);
      va <= a;
      bust <= 1'b1;
      @(posedge clk_i);
      bust <= 1'b0;
   endtask
   // Bus level is only meaningful while someone talks on it
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic dv);
      bst(a);
      rs <= 1'b1;
      @(negedge clk_i);
      rdat = bus;
      chk("hit", 16'((a == 16'hff7a) || (a == 16'hff7c) || (a == 16'hff7e)), 16'(hit));
      chk("drive", 16'(dv), 16'(drv));
      if (dv | yl) begin
         chk("bus", e, bus);
      end
      @(posedge clk_i);
      rs <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bst(a);
      ws <= 1'b1;
      wd <= d;
      @(posedge clk_i);
      ws <= 1'b0;
   endtask
   task automatic ev(input int k);
      @(posedge clk_i);
      evt <= 6'(1 << k);
      @(posedge clk_i);
      evt <= 6'h0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      #20000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      logic [3:0] c;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(16'hff7a, 16'h0, 1);
      for (int i = 0; i < 3; i++) begin
         wr(16'hff7a + 16'(2 * i), 16'hffff);
         rd(16'hff7a + 16'(2 * i), 16'(i == 0), 1);
      end
      chk("relocation_active", 16'h1, 16'(relocation_active));
      cons <= 1'b1;
      @(negedge clk_i);
      chk("relocation_active", 16'h0, 16'(relocation_active));
      @(posedge clk_i);
      cons <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         sp <= 3'(i == 3 ? 0 : 1 << i);
         ds <= i[0];
         bst({3'(2 * i + 1), 13'h0});
         ev(0);
         s0 = {8'h0, 1'b0, md_c[2 * i +: 2], i[0], 3'(2 * i + 1), 1'b1};
         // The capture lands on the edge that ends ev; look once it has settled
         @(negedge clk_i);
         chk("abort", 16'(i == 3), 16'(abort));
         rd(16'hff7a, s0, 1);
      end
      // Bus end, then a paging error, must both leave the record alone
      sp <= 3'h1;
      bus_end_abandon <= 1'b1;
      bst(16'h2000);
      ev(0);
      bus_end_abandon <= 1'b0;
      ev(1);
      bst(16'h4000);
      ev(0);
      rd(16'hff7a, s0, 1);
      bst(16'h1234);
      ev(4);
      rd(16'hff7e, 16'h1234, 1);
      for (int k = 0; k < 4; k++) begin
         c = 4'(1 << k);
         ev(3);
         rd(16'hff7c, 16'h0, 1);
         general_register_number <= 4'h5;
         kc <= c;
         dec <= 1'b0;
         ev(5);
         general_register_number <= 4'hf;
         dec <= 1'b1;
         ev(5);
         rd(16'hff7c, {1'b1, -c, 3'h6, 1'b0, c, 3'h5}, 1);
         chk("sign", 16'h1, 16'(rdat[15]));
      end
      tv <= 16'h00a8;
      ev(2);
      rd(16'hff7e, 16'h00a8, 1);
      rd(16'hff7c, 16'h0, 1);
      rd(16'hff7a, s0 | 16'h0080, 1);
      bst(16'h0400);
      ev(4);
      rd(16'hff7a, s0, 1);
      rd(16'hff7e, 16'h0400, 1);
      ph <= 1'b1;
      pp <= 16'h5a3c;
      rd(16'h0200, 16'h5a3c, 1);
      yl <= 1'b1;
      rd(16'h0200, 16'h0ff0, 0);
      yl <= 1'b0;
      @(negedge clk_i);
      chk("drive", 16'h0, 16'(drv));
      @(posedge clk_i);
      ph <= 1'b0;
      rd(16'hff78, 16'h0, 0);
      rd(16'hfffa, 16'h0, 0);
      end_of_test;
   end
endmodule
